// ==== design/i2csie_pkg.sv ====
/*
 Constants, register indices and carrier types for the two-wire status and
 interrupt-enable block. Assumes the CPU special-function register port and the
 bus shifting engine share the system clock; only the clock line is foreign.
*/
package i2csie_pkg;
   // Register indices within the controller's SFR module
   localparam logic [3:0] IDX_BUF = 4'h4;
   localparam logic [3:0] IDX_ST = 4'h5;
   localparam logic [3:0] IDX_IE = 4'h6;
   localparam logic [15:0] ST_RESET = 16'h0000;
   localparam logic [15:0] IE_RESET = 16'h0000;
   localparam logic [15:0] IE_USED = 16'h07FF;
   localparam logic [15:0] RD_IDLE = 16'h0000;
   // Event flags occupy status bits 9:0
   localparam int unsigned NFLAG = 10;
   localparam logic [9:0] FLAG_NONE = 10'h000;
   localparam logic [9:0] SW_SET_MASK = 10'h333;
   localparam logic [9:0] OVR_MASK = 10'h200;
   localparam logic [2:0] RSVD_ZERO = 3'h0;
   localparam int unsigned B_START = 0;
   localparam int unsigned B_TXD = 1;
   localparam int unsigned B_RXR = 2;
   localparam int unsigned B_STR = 3;
   localparam int unsigned B_TO = 4;
   localparam int unsigned B_AM = 5;
   localparam int unsigned B_AL = 6;
   localparam int unsigned B_NACK = 7;
   localparam int unsigned B_GC = 8;
   localparam int unsigned B_OVR = 9;
   localparam int unsigned B_STREN = 10;
   // General-call address is all zero in the seven address bits
   localparam logic [6:0] GC_ADDR = 7'h00;

   // One-cycle event pulses from the shifting engine
   typedef struct packed {
      logic start_det;
      logic stop_det;
      logic tx_done;
      logic rx_byte;
      logic nack;
      logic arb_lost;
      logic start_fail;
      logic op_begin;
      logic op_end;
      logic stretch_pt;
      logic addr_valid;
   } i2csie_evt_t;

   // CPU special-function register access, one cycle per access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] idx;
      logic [15:0] wdata;
   } i2csie_sfr_t;
endpackage

// ==== design/i2csie_scl_mon.sv ====
/*
 Clock-line monitor: three-stage synchroniser for the foreign clock line and a
 low-time counter for master timeout. Assumes clk_in is the system clock.
*/
`timescale 1ns/1ps
module i2csie_scl_mon
   import i2csie_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic master_in,
   input wire logic [15:0] timeout_value_in,
   output logic level_out,
   output logic timeout_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   logic [16:0] cnt_r;
   logic timeout_r;
   wire logic agree = (s2_r == s3_r);
   wire logic low_master = master_in & ~level_r;
   wire logic at_limit = (cnt_r == {1'b0, timeout_value_in});

   // Level accepted only when stages two and three agree; stage one feeds s2 alone
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         level_r <= 1'b1;
      end else begin
         s1_r <= scl_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (agree) begin
            level_r <= s3_r;
         end
      end
   end

   // Counter stops one past the limit so the timeout fires once per low period
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= 17'h00000;
         timeout_r <= 1'b0;
      end else begin
         timeout_r <= low_master & at_limit;
         if (!low_master) begin
            cnt_r <= 17'h00000;
         end else if (cnt_r <= {1'b0, timeout_value_in}) begin
            cnt_r <= cnt_r + 17'h00001;
         end
      end
   end

   assign level_out = level_r;
   assign timeout_out = timeout_r;
endmodule

// ==== design/i2csie_core.sv ====
/*
 Status flags, interrupt enables and the interrupt request of the two-wire
 controller, reached over the CPU special-function register port.
 Assumes the shifting engine delivers one-cycle event pulses on clk_in and
 that the clock line is an open-drain wire resolved outside this module.
*/
`timescale 1ns/1ps
module i2csie_core
   import i2csie_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire i2csie_sfr_t sfr_in,
   input wire i2csie_evt_t evt_in,
   input wire logic [9:0] rx_addr_in,
   input wire logic [9:0] own_slave_addr_in,
   input wire logic module_enable_in,
   input wire logic master_mode_in,
   input wire logic [15:0] timeout_value_in,
   input wire logic scl_in,
   output logic [15:0] sfr_rdata_out,
   output logic scl_drv_out,
   output logic scl_oe_out,
   output logic irq_out,
   output logic master_clr_out,
   output logic gc_respond_out
);
   logic [9:0] flags_r;
   logic [9:0] flags_nxt;
   logic [15:0] ie_r;
   logic op_busy_r;
   logic op_busy_nxt;
   logic bus_busy_r;
   logic bus_busy_nxt;
   logic rx_pend_r;
   logic [15:0] rdata_r;
   logic scl_oe_r;
   logic irq_r;
   logic master_clr_r;
   logic scl_level;
   logic scl_timeout;

   function automatic logic hit(input i2csie_sfr_t req, input logic [3:0] idx);
      hit = (req.idx == idx);
   endfunction

   i2csie_scl_mon u_scl_mon (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .scl_in(scl_in),
      .master_in(master_mode_in),
      .timeout_value_in(timeout_value_in),
      .level_out(scl_level),
      .timeout_out(scl_timeout)
   );

   // Access decode
   wire logic st_wr = sfr_in.wr & hit(sfr_in, IDX_ST);
   wire logic ie_wr = sfr_in.wr & hit(sfr_in, IDX_IE);
   wire logic st_rd = sfr_in.rd & hit(sfr_in, IDX_ST);
   wire logic ie_rd = sfr_in.rd & hit(sfr_in, IDX_IE);
   wire logic buf_rd = sfr_in.rd & hit(sfr_in, IDX_BUF);
   wire logic [9:0] wflags = sfr_in.wdata[9:0];

   // Hardware event qualification
   wire logic str_set = ie_r[B_STREN] & evt_in.stretch_pt;
   wire logic to_set = master_mode_in & (evt_in.start_fail | scl_timeout);
   wire logic am_set = evt_in.addr_valid & (rx_addr_in == own_slave_addr_in);
   wire logic al_set = master_mode_in & evt_in.arb_lost;
   wire logic gc_set = evt_in.addr_valid & (rx_addr_in[6:0] == GC_ADDR) & ie_r[B_GC];
   wire logic ovr_set = evt_in.rx_byte & rx_pend_r;

   wire logic [9:0] hw_set = {ovr_set, gc_set, evt_in.nack, al_set, am_set, to_set,
                              str_set, evt_in.rx_byte, evt_in.tx_done, evt_in.start_det};

   // Write of zero clears, except overrun which only a buffer read clears
   wire logic [9:0] kept = st_wr ? (flags_r & (wflags | OVR_MASK)) : flags_r;
   wire logic [9:0] sw_set = st_wr ? (wflags & SW_SET_MASK) : FLAG_NONE;
   wire logic [9:0] ovr_clr = buf_rd ? OVR_MASK : FLAG_NONE;

   // Hardware set wins over any clear in the same cycle; hw-only bits lack sw_set
   always_comb begin
      flags_nxt = hw_set | ((kept | sw_set) & ~ovr_clr);
   end

   // Operation busy: begin wins over a coincident end
   always_comb begin
      op_busy_nxt = op_busy_r;
      if (evt_in.op_begin) begin
         op_busy_nxt = 1'b1;
      end else if (evt_in.op_end | to_set) begin
         op_busy_nxt = 1'b0;
      end
   end

   // Bus busy follows START and STOP, forced low while disabled
   always_comb begin
      bus_busy_nxt = bus_busy_r;
      if (!module_enable_in) begin
         bus_busy_nxt = 1'b0;
      end else if (evt_in.start_det) begin
         bus_busy_nxt = 1'b1;
      end else if (evt_in.stop_det) begin
         bus_busy_nxt = 1'b0;
      end
   end

   // Read-back images
   wire logic [15:0] st_img = {bus_busy_r, op_busy_r, RSVD_ZERO, scl_level, flags_r};
   wire logic [15:0] rd_val = st_rd ? st_img : (ie_rd ? ie_r : RD_IDLE);
   wire logic irq_nxt = |(flags_r & ie_r[9:0]);

   // Flag and status state
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags_r <= ST_RESET[9:0];
         op_busy_r <= 1'b0;
         bus_busy_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         op_busy_r <= op_busy_nxt;
         bus_busy_r <= bus_busy_nxt;
      end
   end

   // Unread-byte tracker; a read in the same cycle as a new byte leaves one pending
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_pend_r <= 1'b0;
      end else if (evt_in.rx_byte) begin
         rx_pend_r <= 1'b1;
      end else if (buf_rd) begin
         rx_pend_r <= 1'b0;
      end
   end

   // Enable register; bits above 10 are not stored and read zero
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ie_r <= IE_RESET;
      end else if (ie_wr) begin
         ie_r <= sfr_in.wdata & IE_USED;
      end
   end

   // Registered outputs; clock line held low exactly while stretch flag stands
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_r <= RD_IDLE;
         scl_oe_r <= 1'b0;
         irq_r <= 1'b0;
         master_clr_r <= 1'b0;
      end else begin
         rdata_r <= rd_val;
         scl_oe_r <= flags_nxt[B_STR];
         irq_r <= irq_nxt;
         master_clr_r <= al_set;
      end
   end

   assign sfr_rdata_out = rdata_r;
   assign scl_drv_out = 1'b0;
   assign scl_oe_out = scl_oe_r;
   assign irq_out = irq_r;
   assign master_clr_out = master_clr_r;
   assign gc_respond_out = ie_r[B_GC];

   // All checks run on the system clock and rest while reset stands
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   // Clock line follows the stretch flag on the same edge
   AST_STRETCH_HOLD: assert property (flags_r[B_STR] && !str_set |-> ##1 scl_oe_out == flags_r[B_STR])
      else $error("clock line not held with stretch flag");

   // Clearing the stretch flag releases the clock line
   AST_STR_RELEASE: assert property (flags_r[B_STR] && st_wr && !wflags[B_STR] && !str_set |=> !scl_oe_out)
      else $error("clock line not released after clear");

   // A stretch only starts from an enabled stretch point
   AST_STRETCH_CAUSE: assert property ($rose(scl_oe_out) |-> $past(ie_r[B_STREN] && evt_in.stretch_pt))
      else $error("stretch without enabled stretch point");

   // Start failure in master mode raises timeout and ends the operation
   AST_TIMEOUT: assert property (master_mode_in && evt_in.start_fail && !evt_in.op_begin
      |=> flags_r[B_TO] && !op_busy_r)
      else $error("start failure did not raise timeout");

   // Without master mode no hardware timeout appears
   AST_TO_SLAVE: assert property (!master_mode_in && !flags_r[B_TO] && !(st_wr && wflags[B_TO])
      |=> !flags_r[B_TO])
      else $error("timeout raised outside master mode");

   // Own address seen in the address stage
   AST_ADDR_MATCH: assert property (evt_in.addr_valid && rx_addr_in == own_slave_addr_in |=> flags_r[B_AM])
      else $error("address match flag missing");

   // Arbitration loss flags and sends a single master-clear pulse
   AST_ARB_LOSS: assert property (al_set |=> flags_r[B_AL] && master_clr_out ##1 (!master_clr_out || $past(al_set)))
      else $error("arbitration loss handling wrong");

   // A slave cannot lose arbitration
   AST_AL_MASTER: assert property (evt_in.arb_lost && !master_mode_in && !flags_r[B_AL]
      |=> !flags_r[B_AL] && !master_clr_out)
      else $error("arbitration loss outside master mode");

   // Not-acknowledge always lands in the flag
   AST_NACK: assert property (evt_in.nack |=> flags_r[B_NACK])
      else $error("nack flag missing");

   // General call ignored while its enable is clear
   AST_GC_GATED: assert property (!ie_r[B_GC] && !flags_r[B_GC] && !(st_wr && wflags[B_GC]) |=> !flags_r[B_GC])
      else $error("general call flag set while disabled");

   // General call taken while enabled
   AST_GC_SET: assert property (evt_in.addr_valid && rx_addr_in[6:0] == GC_ADDR && ie_r[B_GC] |=> flags_r[B_GC])
      else $error("general call flag missing");

   // A byte arriving while one is unread is an overrun
   AST_OVR_SET: assert property (evt_in.rx_byte && rx_pend_r && !buf_rd |=> flags_r[B_OVR])
      else $error("overrun not flagged");

   // Zero written to overrun leaves it standing
   AST_OVR_KEEP: assert property (flags_r[B_OVR] && st_wr && !wflags[B_OVR] && !buf_rd |=> flags_r[B_OVR])
      else $error("zero write cleared overrun");

   // Buffer read clears overrun
   AST_OVR_CLR: assert property (buf_rd && !ovr_set |=> !flags_r[B_OVR])
      else $error("buffer read left overrun set");

   // Status read shows the synchronised clock level
   AST_SCL_READ: assert property (st_rd |=> sfr_rdata_out[B_STREN] == $past(scl_level))
      else $error("clock line level misreported");

   // Reserved status bits never show anything
   AST_RSVD_ZERO: assert property (sfr_rdata_out[13:11] == RSVD_ZERO)
      else $error("reserved status bits not zero");

   // Operation start raises busy
   AST_OP_BUSY: assert property (evt_in.op_begin |=> op_busy_r)
      else $error("operation busy not raised");

   // Operation end drops busy
   AST_OP_END: assert property (evt_in.op_end && !evt_in.op_begin |=> !op_busy_r)
      else $error("operation busy not dropped at end");

   // Master timeout aborts the operation
   AST_TO_ABORT: assert property (to_set && !evt_in.op_begin |=> !op_busy_r)
      else $error("timeout did not abort operation");

   // Disabled module never reports a busy bus
   AST_BUS_OFF: assert property (!module_enable_in |=> !bus_busy_r)
      else $error("bus busy while disabled");

   // START marks the bus busy
   AST_BUS_SET: assert property (module_enable_in && evt_in.start_det |=> bus_busy_r)
      else $error("bus busy not set by start");

   // STOP frees the bus
   AST_BUS_CLR: assert property (module_enable_in && evt_in.stop_det && !evt_in.start_det |=> !bus_busy_r)
      else $error("bus busy not cleared by stop");

   // Software may set the timeout flag
   AST_SW_SET: assert property (st_wr && wflags[B_TO] |=> flags_r[B_TO])
      else $error("software set of timeout ignored");

   // Software cannot set arbitration loss
   AST_HW_ONLY: assert property (st_wr && !hw_set[B_AL] && !flags_r[B_AL] |=> !flags_r[B_AL])
      else $error("software set a hardware-only flag");

   // Software cannot set the nack flag
   AST_HW_ONLY_NACK: assert property (st_wr && !evt_in.nack && !flags_r[B_NACK] |=> !flags_r[B_NACK])
      else $error("software set the nack flag");

   // Software cannot set the stretch flag
   AST_HW_ONLY_STR: assert property (st_wr && !str_set && !flags_r[B_STR] |=> !flags_r[B_STR])
      else $error("software set the stretch flag");

   // Written enable word reads back through its stored bits
   AST_IE_RW: assert property (ie_wr ##1 !ie_wr ##1 ie_rd |=> sfr_rdata_out == ($past(sfr_in.wdata, 3) & IE_USED))
      else $error("enable register read-back wrong");

   // Enabled START flag requests an interrupt
   AST_IRQ_START: assert property (flags_r[B_START] && ie_r[B_START] |=> irq_out)
      else $error("start flag raised no interrupt");

   // Enabled stretch flag requests an interrupt
   AST_IRQ_STR: assert property (flags_r[B_STR] && ie_r[B_STR] |=> irq_out)
      else $error("stretch flag raised no interrupt");

   // Enabled overrun requests an interrupt
   AST_IRQ: assert property (flags_r[B_OVR] && ie_r[B_OVR] |=> irq_out)
      else $error("enabled flag raised no interrupt");

   // Nothing masked in means no request
   AST_IRQ_NONE: assert property ((flags_r & ie_r[9:0]) == FLAG_NONE |=> !irq_out)
      else $error("interrupt without an enabled flag");

   // All enables clear means no request
   AST_IRQ_MASK: assert property (ie_r[9:0] == FLAG_NONE |=> !irq_out)
      else $error("interrupt with all sources masked");

   // Main scenarios worth seeing at least once
   COV_STRETCH: cover property (str_set ##1 scl_oe_out ##[1:20] !scl_oe_out);
   COV_OVERRUN: cover property (ovr_set ##[1:10] buf_rd);
   COV_ARB: cover property (al_set ##1 irq_out);
   COV_BUS: cover property (evt_in.start_det ##[1:50] evt_in.stop_det);
   COV_TIMEOUT: cover property (to_set ##1 flags_r[B_TO]);
endmodule

// ==== test/i2csie_bus_peer.sv ====
/*
 Far-side model of the two-wire bus: another master that clocks frames or
 holds the clock line low. Assumes the bench resolves the open-drain wire
 with a pull-up, so a released line reads high.
*/
`timescale 1ns/1ps
module i2csie_bus_peer (
   input wire logic run_in,
   input wire logic hold_in,
   output logic pull_low_out
);
   logic phase_r = 1'b0;

   // Link clock of 320 ns, only within frames; stands still between them
   always begin
      #160;
      phase_r = run_in ? ~phase_r : 1'b0;
   end

   // Open drain: the peer only ever pulls low, never drives high
   assign pull_low_out = hold_in | (run_in & phase_r);
endmodule

// ==== test/tb.sv ====
/*
 Self-checking bench for the status and interrupt-enable block.
 Assumes a pull-up on the clock line and one-cycle event pulses on clk_in.
*/
`timescale 1ns/1ps
module tb;
   import i2csie_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   i2csie_sfr_t sfr = '0;
   i2csie_evt_t evt = '0;
   logic [9:0] rx_addr = 10'h155;
   logic men = 1'b1;
   logic mst = 1'b0;
   logic [15:0] tov = 16'h0014;
   logic scl, scl_oe, irq, mclr, gcr, pull, run = 1'b0, hold = 1'b0;
   logic mclr_seen = 1'b0;
   logic [15:0] rdata;
   int mismatches = 0;
   int samples_checked = 0;
   int cyc = 0;
   // Event that raises each flag 0..9, msb first as in the struct
   logic [10:0] ctab [10] = '{11'h400, 11'h100, 11'h080, 11'h002, 11'h010,
                             11'h001, 11'h020, 11'h040, 11'h001, 11'h080};

   // Open-drain clock line with pull-up
   assign scl = ~(scl_oe | pull);

   i2csie_core u_i2csie_core (.clk_in(clk_in), .rst_in(rst_in), .sfr_in(sfr), .evt_in(evt),
      .rx_addr_in(rx_addr), .own_slave_addr_in(10'h155), .module_enable_in(men),
      .master_mode_in(mst), .timeout_value_in(tov), .scl_in(scl), .sfr_rdata_out(rdata),
      .scl_drv_out(), .scl_oe_out(scl_oe), .irq_out(irq), .master_clr_out(mclr),
      .gc_respond_out(gcr));

   i2csie_bus_peer u_i2csie_bus_peer (.run_in(run), .hold_in(hold), .pull_low_out(pull));

   // 25 MHz system clock
   initial begin
      forever #20 clk_in = ~clk_in;
   end

   // Hang guard and capture of the one-cycle master-clear pulse
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (mclr)
         mclr_seen <= 1'b1;
      if (cyc == 20000) begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      @(negedge clk_in);
      sfr.wr = 1'b1;
      sfr.idx = i;
      sfr.wdata = d;
      @(negedge clk_in);
      sfr.wr = 1'b0;
   endtask

   // Read data stands from the taking edge and is checked half a cycle later; compare under mask
   task automatic rd(input logic [3:0] i, input logic [15:0] m, input logic [15:0] e);
      @(negedge clk_in);
      sfr.rd = 1'b1;
      sfr.idx = i;
      @(negedge clk_in);
      sfr.rd = 1'b0;
      chk(rdata & m, e);
   endtask

   task automatic pulse(input logic [10:0] e);
      @(negedge clk_in);
      evt = i2csie_evt_t'(e);
      @(negedge clk_in);
      evt = '0;
   endtask

   task automatic print_verdict();
      if (mismatches == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (8) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (5) @(negedge clk_in);
      rd(IDX_IE, 16'hFFFF, 16'h0000);
      rd(IDX_ST, 16'hFFFF, 16'h0400);
      wr(IDX_IE, 16'hFFFF);
      rd(IDX_IE, 16'hFFFF, 16'h07FF);
      chk(16'(gcr), 16'h0001);
      wr(IDX_IE, 16'h0000);
      // Software sets only the settable flags; zero clears all but overrun
      wr(IDX_ST, 16'hFFFF);
      rd(IDX_ST, 16'hFBFF, 16'h0333);
      wr(IDX_ST, 16'h0000);
      rd(IDX_ST, 16'hFBFF, 16'h0200);
      rd(IDX_BUF, 16'hFFFF, 16'h0000);
      rd(IDX_ST, 16'hFBFF, 16'h0000);
      // Events that must be ignored without master mode or enables
      rx_addr = 10'h000;
      pulse(11'h020);
      pulse(11'h010);
      pulse(11'h001);
      pulse(11'h002);
      rd(IDX_ST, 16'h03FF, 16'h0000);
      chk(16'(mclr_seen), 16'h0000);
      // Each flag raised by its event, then gated by its enable bit
      mst = 1'b1;
      for (int b = 0; b < 10; b++) begin
         rx_addr = (b == 8) ? 10'h000 : 10'h155;
         wr(IDX_IE, (b == 8) ? 16'h0500 : 16'h0400);
         pulse(ctab[b]);
         if (b == 9)
            pulse(ctab[b]);
         rd(IDX_ST, 16'(1 << b), 16'(1 << b));
         chk(16'(irq), 16'(b == 8));
         if (b == 3)
            chk(16'(scl_oe), 16'h0001);
         if (b == 6)
            chk(16'(mclr_seen), 16'h0001);
         wr(IDX_IE, 16'h0400 | 16'(1 << b));
         rd(IDX_IE, 16'hFFFF, 16'h0400 | 16'(1 << b));
         chk(16'(irq), 16'h0001);
         wr(IDX_IE, 16'h0400);
         rd(IDX_ST, 16'(1 << b), 16'(1 << b));
         chk(16'(irq), 16'h0000);
         wr(IDX_ST, 16'h0000);
         rd(IDX_BUF, 16'hFFFF, 16'h0000);
         pulse(11'h200);
         rd(IDX_ST, 16'hC3FF, 16'h0000);
      end
      chk(16'(scl_oe), 16'h0000);
      // Bus busy follows START and STOP and drops with the module disabled
      pulse(11'h400);
      rd(IDX_ST, 16'h8000, 16'h8000);
      pulse(11'h200);
      rd(IDX_ST, 16'h8000, 16'h0000);
      pulse(11'h400);
      men = 1'b0;
      rd(IDX_ST, 16'h8000, 16'h0000);
      men = 1'b1;
      // Operation busy from begin to end
      pulse(11'h008);
      rd(IDX_ST, 16'h4000, 16'h4000);
      pulse(11'h004);
      rd(IDX_ST, 16'h4000, 16'h0000);
      // Short clock-low phases of a frame must not time out
      pulse(11'h008);
      run = 1'b1;
      repeat (60) @(negedge clk_in);
      run = 1'b0;
      rd(IDX_ST, 16'h4010, 16'h4000);
      // Peer holds the clock low past the limit: timeout aborts the operation
      hold = 1'b1;
      repeat (40) @(negedge clk_in);
      rd(IDX_ST, 16'h4410, 16'h0010);
      hold = 1'b0;
      repeat (6) @(negedge clk_in);
      rd(IDX_ST, 16'h0400, 16'h0400);
      print_verdict();
   end
endmodule
